// ---- hdl/fcd_fuse_decoder.v ----
`timescale 1ns/1ps
`include "fcd_map.vh"
module fcd_fuse_decoder #(
   parameter FLASH_BLOCKS = 16,
   parameter CYC_PER_MS = `FCD_CLK_HZ / 1000,
   parameter GUARD_CYCLES = `FCD_GUARD_SLOW_CYCLES
) (
   input wire sys_clk_i,
   input wire rst_n_i,
   input wire slow_osc_i,
   input wire [7:0] fuse_timer_i,
   input wire [7:0] fuse_syscfg_a_i,
   input wire [7:0] fuse_startup_i,
   input wire [7:0] fuse_app_end_i,
   input wire [7:0] fuse_boot_end_i,
   input wire [7:0] fuse_lock_i,
   input wire fault_detect_setting_i,
   input wire debug_entry_i,
   input wire [3:0] compare_out_i,
   input wire chip_erase_i,
   input wire [15:0] flash_addr_i,
   input wire dbg_sysbus_req_i,
   input wire dbg_sib_req_i,
   input wire pin_gpio_out_i,
   input wire pin_gpio_oe_n_i,
   input wire [3:0] reg_addr_i,
   input wire [7:0] reg_wdata_i,
   input wire reg_wr_i,
   input wire reg_rd_i,
   output reg [7:0] reg_rdata_o,
   output wire [7:0] timer_fault_control_o,
   output wire [3:0] compare_pin_o,
   output wire [3:0] compare_pin_oe_n_o,
   output wire [1:0] scan_source_select_o,
   output wire [15:0] scan_end_addr_o,
   output wire scan_disabled_o,
   output wire [1:0] reset_pin_function_o,
   output wire pin_is_gpio_o,
   output wire pin_is_debug_o,
   output wire pin_is_reset_o,
   output wire pin_out_o,
   output wire pin_oe_n_o,
   output wire pin_guard_active_o,
   output wire erase_eeprom_o,
   output wire startup_done_o,
   output wire addr_in_boot_o,
   output wire addr_in_app_code_o,
   output wire addr_in_app_data_o,
   output wire locked_o,
   output wire dbg_sysbus_grant_o,
   output wire dbg_sib_grant_o
);
   reg [7:0] timer_r;
   reg [7:0] syscfg_a_r;
   reg [2:0] startup_r;
   reg [7:0] app_end_r;
   reg [7:0] boot_end_r;
   reg [7:0] lock_r;
   reg loaded_r;
   reg [3:0] cmp_level_r;
   reg [3:0] cmp_level_nxt;
   reg reset_seen_r;
   wire guard_active;
   wire [1:0] pin_fn;
   wire both_zero;
   wire [15:0] boot_top;
   wire [15:0] app_top;
   wire [15:0] flash_top;
   wire locked;

   // block count to byte address; one block is 256 bytes
   function [15:0] blk_addr;
      input [7:0] blk;
      begin
         blk_addr = {blk, 8'h00};
      end
   endfunction

   // fuse inputs are static while the chip is in reset; taken in the first cycle after release
   always @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         timer_r <= 8'h00;
         syscfg_a_r <= 8'h00;
         startup_r <= 3'h0;
         app_end_r <= 8'h00;
         boot_end_r <= 8'h00;
         lock_r <= 8'h00;
         loaded_r <= 1'b0;
      end else if (!loaded_r) begin
         timer_r <= fuse_timer_i;
         syscfg_a_r <= fuse_syscfg_a_i;
         startup_r <= fuse_startup_i[2:0];
         app_end_r <= fuse_app_end_i;
         boot_end_r <= fuse_boot_end_i;
         lock_r <= fuse_lock_i;
         loaded_r <= 1'b1;
      end else if (reg_wr_i && reg_addr_i == `FCD_OFS_LOCK_KEY) begin
         // new key applies at once; lock value otherwise frozen until next reset
         lock_r <= reg_wdata_i;
      end
   end

   assign timer_fault_control_o = timer_r;

   // compare level: fuse default after reset, reloaded on debug entry when fault detect is set
   always @* begin
      cmp_level_nxt = compare_out_i;
      if (!reset_seen_r || (debug_entry_i && fault_detect_setting_i)) begin
         cmp_level_nxt = timer_r[3:0];
      end
   end
   always @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         cmp_level_r <= 4'h0;
         reset_seen_r <= 1'b0;
      end else begin
         cmp_level_r <= cmp_level_nxt;
         reset_seen_r <= loaded_r;
      end
   end
   assign compare_pin_o = cmp_level_r;
   assign compare_pin_oe_n_o = ~timer_r[7:4];

   // memory scan range
   assign scan_source_select_o = syscfg_a_r[`FCD_SCAN_SRC_HI:`FCD_SCAN_SRC_LO];
   assign scan_disabled_o = scan_source_select_o == `FCD_SCAN_NONE;
   assign flash_top = blk_addr(FLASH_BLOCKS[7:0]) - 16'h0001;
   assign both_zero = boot_end_r == 8'h00 && app_end_r == 8'h00;
   // boot section covers all flash when boot end is zero
   assign boot_top = (boot_end_r == 8'h00) ? flash_top : blk_addr(boot_end_r) - 16'h0001;
   assign app_top = (app_end_r == 8'h00) ? flash_top : blk_addr(app_end_r) - 16'h0001;
   assign scan_end_addr_o = (scan_source_select_o == `FCD_SCAN_BOOT) ? boot_top :
                            (scan_source_select_o == `FCD_SCAN_SCAN_BOOT_AND_APP) ? app_top : flash_top;

   // address classification
   assign addr_in_boot_o = both_zero || boot_end_r == 8'h00 || flash_addr_i <= boot_top;
   assign addr_in_app_code_o = !addr_in_boot_o && flash_addr_i <= app_top;
   assign addr_in_app_data_o = !addr_in_boot_o && !addr_in_app_code_o;

   // reset pin function
   assign pin_fn = syscfg_a_r[`FCD_PIN_FN_HI:`FCD_PIN_FN_LO];
   assign reset_pin_function_o = pin_fn;
   assign pin_is_gpio_o = loaded_r && pin_fn == `FCD_PIN_GPIO;
   assign pin_is_debug_o = loaded_r && pin_fn == `FCD_PIN_DEBUG;
   assign pin_is_reset_o = loaded_r && pin_fn == `FCD_PIN_RESET;

   fcd_pin_guard #(
      .GUARD_CYCLES(GUARD_CYCLES)
   ) u_guard (
      .sys_clk_i(sys_clk_i),
      .rst_n_i(rst_n_i),
      .slow_osc_i(slow_osc_i),
      .guard_active_o(guard_active)
   );
   assign pin_guard_active_o = guard_active;
   // driver held off during guard so a high-voltage debug entry cannot collide
   assign pin_out_o = pin_gpio_out_i;
   assign pin_oe_n_o = !pin_is_gpio_o || guard_active || pin_gpio_oe_n_i;

   // erase policy and lock
   assign locked = lock_r != `FCD_UNLOCK_KEY;
   assign locked_o = locked;
   assign erase_eeprom_o = chip_erase_i && (locked || !syscfg_a_r[`FCD_KEEP_EE_BIT]);
   assign dbg_sysbus_grant_o = dbg_sysbus_req_i && !locked && loaded_r;
   assign dbg_sib_grant_o = dbg_sib_req_i && loaded_r;

   fcd_startup_timer #(
      .CYC_PER_MS(CYC_PER_MS)
   ) u_startup (
      .sys_clk_i(sys_clk_i),
      .rst_n_i(rst_n_i),
      .start_i(reset_seen_r),
      .delay_sel_i(startup_r),
      .done_o(startup_done_o)
   );

   // register read port, data one cycle after strobe
   always @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         reg_rdata_o <= 8'h00;
      end else if (reg_rd_i) begin
         case (reg_addr_i)
            `FCD_OFS_TIMER_FAULT: reg_rdata_o <= timer_r;
            `FCD_OFS_SYSCFG_A: reg_rdata_o <= syscfg_a_r;
            `FCD_OFS_STARTUP: reg_rdata_o <= {5'h00, startup_r};
            `FCD_OFS_APP_END: reg_rdata_o <= app_end_r;
            `FCD_OFS_BOOT_END: reg_rdata_o <= boot_end_r;
            `FCD_OFS_LOCK_KEY: reg_rdata_o <= lock_r;
            // software polls guard here before enabling pin interrupts
            `FCD_OFS_STATUS: reg_rdata_o <= {4'h0, startup_done_o, guard_active, locked, loaded_r};
            default: reg_rdata_o <= 8'h00;
         endcase
      end else begin
         reg_rdata_o <= 8'h00;
      end
   end
endmodule

// ---- hdl/fcd_pin_guard.v ----
`timescale 1ns/1ps
`include "fcd_map.vh"
// counts slow oscillator edges after reset; the oscillator input is asynchronous
module fcd_pin_guard #(
   parameter GUARD_CYCLES = `FCD_GUARD_SLOW_CYCLES
) (
   input wire sys_clk_i,
   input wire rst_n_i,
   input wire slow_osc_i,
   output wire guard_active_o
);
   reg sync1_r;
   reg sync2_r;
   reg sync3_r;
   reg [10:0] cnt_r;
   reg active_r;
   reg [1:0] prime_r;
   wire rise;
   // no edge until the sampling chain holds real pin values, else a high osc at release counts
   assign rise = sync2_r & ~sync3_r & (prime_r == 2'h3);
   always @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         sync1_r <= 1'b0;
         sync2_r <= 1'b0;
         sync3_r <= 1'b0;
         cnt_r <= 11'h000;
         active_r <= 1'b1;
         prime_r <= 2'h0;
      end else begin
         if (prime_r != 2'h3) begin
            prime_r <= prime_r + 2'h1;
         end
         sync1_r <= slow_osc_i;
         sync2_r <= sync1_r;
         sync3_r <= sync2_r;
         if (active_r && rise) begin
            if (cnt_r == GUARD_CYCLES[10:0] - 11'h001) begin
               active_r <= 1'b0;
            end
            cnt_r <= cnt_r + 11'h001;
         end
      end
   end
   assign guard_active_o = active_r;
endmodule

// ---- hdl/fcd_startup_timer.v ----
`timescale 1ns/1ps
`include "fcd_map.vh"
// counts milliseconds of system clock; long counts are parameters
module fcd_startup_timer #(
   parameter CYC_PER_MS = `FCD_CLK_HZ / 1000
) (
   input wire sys_clk_i,
   input wire rst_n_i,
   input wire start_i,
   input wire [2:0] delay_sel_i,
   output wire done_o
);
   reg [15:0] tick_r;
   reg [6:0] ms_r;
   reg run_r;
   reg done_r;
   function [6:0] ms_of;
      input [2:0] sel;
      begin
         if (sel == 3'h0) begin
            ms_of = 7'h00;
         end else begin
            ms_of = 7'h01 << (sel - 3'h1);
         end
      end
   endfunction
   always @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         tick_r <= 16'h0000;
         ms_r <= 7'h00;
         run_r <= 1'b0;
         done_r <= 1'b0;
      end else if (start_i && !run_r && !done_r) begin
         run_r <= 1'b1;
         tick_r <= 16'h0000;
         ms_r <= 7'h00;
         if (ms_of(delay_sel_i) == 7'h00) begin
            run_r <= 1'b0;
            done_r <= 1'b1;
         end
      end else if (run_r) begin
         if (tick_r == CYC_PER_MS[15:0] - 16'h0001) begin
            tick_r <= 16'h0000;
            if (ms_r + 7'h01 == ms_of(delay_sel_i)) begin
               run_r <= 1'b0;
               done_r <= 1'b1;
            end
            ms_r <= ms_r + 7'h01;
         end else begin
            tick_r <= tick_r + 16'h0001;
         end
      end
   end
   assign done_o = done_r;
endmodule

// ---- include/fcd_map.vh ----
`ifndef FCD_MAP_VH
`define FCD_MAP_VH
// fuse byte offsets, word index on the register port
`define FCD_OFS_TIMER_FAULT 4'h4
`define FCD_OFS_SYSCFG_A 4'h5
`define FCD_OFS_STARTUP 4'h6
`define FCD_OFS_APP_END 4'h7
`define FCD_OFS_BOOT_END 4'h8
`define FCD_OFS_LOCK_KEY 4'hA
// status register of own choosing
`define FCD_OFS_STATUS 4'hC
// field positions in system_config_fuse_a
`define FCD_SCAN_SRC_HI 7
`define FCD_SCAN_SRC_LO 6
`define FCD_PIN_FN_HI 3
`define FCD_PIN_FN_LO 2
`define FCD_KEEP_EE_BIT 0
// codes
`define FCD_SCAN_FLASH 2'h0
`define FCD_SCAN_BOOT 2'h1
`define FCD_SCAN_SCAN_BOOT_AND_APP 2'h2
`define FCD_SCAN_NONE 2'h3
`define FCD_PIN_GPIO 2'h0
`define FCD_PIN_DEBUG 2'h1
`define FCD_PIN_RESET 2'h2
`define FCD_UNLOCK_KEY 8'hC5
// timing
`define FCD_GUARD_SLOW_CYCLES 768
`define FCD_CLK_HZ 25000000
`define FCD_STARTUP_MAX_MS 64
`endif

// ---- tb/fcd_dbg_host.sv ----
`timescale 1ns/1ps
// host tool asks whether locked or not, no kinder than the real one
module fcd_dbg_host (
   input wire sys_clk_i,
   input wire want_bus_i,
   input wire want_sib_i,
   input wire grant_i,
   output reg bus_req_o = 1'b0,
   output reg sib_req_o = 1'b0,
   output reg got_bus_o = 1'b0
);
   always @(posedge sys_clk_i) begin
      bus_req_o <= want_bus_i;
      sib_req_o <= want_sib_i;
      got_bus_o <= bus_req_o && grant_i;
   end
endmodule

// ---- tb/fcd_fuse_decoder_tb.sv ----
`timescale 1ns/1ps
module fcd_fuse_decoder_tb;
   reg sys_clk_i = 0, rst_n_i = 0, slow_osc_i = 0, fault_detect_setting_i = 0, debug_entry_i = 0;
   reg chip_erase_i = 0, pin_gpio_out_i = 0, pin_gpio_oe_n_i = 1, reg_wr_i = 0, reg_rd_i = 0, wb = 0, ws = 0;
   reg [7:0] fuse_timer_i = 0, fuse_syscfg_a_i = 0, fuse_startup_i = 0, fuse_app_end_i = 0;
   reg [7:0] fuse_boot_end_i = 0, fuse_lock_i = 0, reg_wdata_i = 0, d;
   reg [3:0] compare_out_i = 0, reg_addr_i = 0, k;
   reg [15:0] flash_addr_i = 0, e;
   wire dbg_sysbus_req_i, dbg_sib_req_i, got;
   wire [7:0] reg_rdata_o, timer_fault_control_o;
   wire [3:0] compare_pin_o, compare_pin_oe_n_o;
   wire [1:0] scan_source_select_o, reset_pin_function_o;
   wire [15:0] scan_end_addr_o;
   wire scan_disabled_o, pin_is_gpio_o, pin_is_debug_o, pin_is_reset_o, pin_out_o, pin_oe_n_o;
   wire pin_guard_active_o, erase_eeprom_o, startup_done_o, addr_in_boot_o, addr_in_app_code_o;
   wire addr_in_app_data_o, locked_o, dbg_sysbus_grant_o, dbg_sib_grant_o;
   integer fail_count = 0, checks = 0, cyc = 0, n;
   fcd_fuse_decoder #(.FLASH_BLOCKS(16), .CYC_PER_MS(4), .GUARD_CYCLES(8)) DUT (.*);
   fcd_dbg_host u_host (.sys_clk_i(sys_clk_i), .want_bus_i(wb), .want_sib_i(ws), .grant_i(dbg_sysbus_grant_o),
      .bus_req_o(dbg_sysbus_req_i), .sib_req_o(dbg_sib_req_i), .got_bus_o(got));
   initial begin
      forever #20 sys_clk_i = ~sys_clk_i;
   end
   // slow oscillator free running, unrelated in phase
   initial begin
      forever #15259 slow_osc_i = ~slow_osc_i;
   end
   always @(posedge sys_clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fail_count = fail_count + 1;
         complete_run;
      end
   end
   task chk(input [15:0] x, input [15:0] a);
      begin
         checks = checks + 1;
         if (a !== x) begin
            fail_count = fail_count + 1;
            $display("ERROR t=%0t exp=%h got=%h", $time, x, a);
         end
      end
   endtask
   task tick;
      begin
         @(posedge sys_clk_i);
         #1;
      end
   endtask
   task boot(input [7:0] tf, cf, su, ae, be, lk);
      begin
         @(posedge sys_clk_i);
         rst_n_i <= 0;
         fuse_timer_i <= tf;
         fuse_syscfg_a_i <= cf;
         fuse_startup_i <= su;
         fuse_app_end_i <= ae;
         fuse_boot_end_i <= be;
         fuse_lock_i <= lk;
         repeat (12) @(posedge sys_clk_i);
         rst_n_i <= 1;
         tick;
         tick;
      end
   endtask
   task rdchk(input [3:0] a, input [7:0] x);
      begin
         @(posedge sys_clk_i);
         reg_rd_i <= 1;
         reg_addr_i <= a;
         tick;
         reg_rd_i <= 0;
         chk(x, reg_rdata_o);
      end
   endtask
   task wr(input [7:0] v);
      begin
         @(posedge sys_clk_i);
         reg_wr_i <= 1;
         reg_addr_i <= 4'hA;
         reg_wdata_i <= v;
         tick;
         reg_wr_i <= 0;
      end
   endtask
   task fa(input [15:0] a, input [2:0] x);
      begin
         @(posedge sys_clk_i);
         flash_addr_i <= a;
         #1 chk(x, {addr_in_boot_o, addr_in_app_code_o, addr_in_app_data_o});
      end
   endtask
   task t_timer;
      begin
         boot(8'hA5, 8'h00, 8'h00, 8'h00, 8'h00, 8'hC5);
         chk(8'hA5, timer_fault_control_o);
         chk(4'h5, compare_pin_oe_n_o);
         chk(4'h5, compare_pin_o);
         compare_out_i <= 4'hA;
         debug_entry_i <= 1;
         fuse_timer_i <= 8'h3C;
         repeat (3) tick;
         chk(4'hA, compare_pin_o);
         fault_detect_setting_i <= 1;
         repeat (3) tick;
         chk(4'h5, compare_pin_o);
         chk(8'hA5, timer_fault_control_o);
         debug_entry_i <= 0;
         $display("timer test done");
      end
   endtask
   task t_regs;
      begin
         boot(8'h12, 8'h05, 8'h03, 8'h06, 8'h02, 8'h3A);
         rdchk(4'h4, 8'h12);
         rdchk(4'h6, 8'h03);
         rdchk(4'h5, 8'h05);
         rdchk(4'h7, 8'h06);
         rdchk(4'h8, 8'h02);
         rdchk(4'hA, 8'h3A);
         rdchk(4'h3, 8'h00);
         wb <= 1;
         ws <= 1;
         chip_erase_i <= 1;
         repeat (3) tick;
         chk(1, locked_o);
         chk(3'b001, {got, dbg_sysbus_grant_o, dbg_sib_grant_o});
         chk(1, erase_eeprom_o);
         wr(8'hC5);
         chk(2'b00, {locked_o, erase_eeprom_o});
         tick;
         chk(2'b11, {got, dbg_sysbus_grant_o});
         wr(8'hC4);
         chk(1, locked_o);
         wb <= 0;
         ws <= 0;
         $display("register test done");
      end
   endtask
   task t_scan;
      begin
         for (k = 0; k < 4; k = k + 1) begin
            d = {k[1:0], 2'b00, (k == 3) ? 2'h2 : k[1:0], 2'b00};
            boot(8'h00, d, 8'h00, 8'h06, 8'h02, 8'hC5);
            e = (k == 0) ? 16'h0FFF : (k == 1) ? 16'h01FF : 16'h05FF;
            chk({k[1:0], k == 3}, {scan_source_select_o, scan_disabled_o});
            if (k < 3)
               chk(e, scan_end_addr_o);
            chk({d[3:2], d[3:2] == 0, d[3:2] == 1, d[3:2] == 2}, {reset_pin_function_o, pin_is_gpio_o,
               pin_is_debug_o, pin_is_reset_o});
            chk(1, erase_eeprom_o);
         end
         chip_erase_i <= 0;
         boot(8'h00, 8'h00, 8'h00, 8'h06, 8'h02, 8'hC5);
         fa(16'h01FF, 3'b100);
         fa(16'h0200, 3'b010);
         fa(16'h0600, 3'b001);
         boot(8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'hC5);
         fa(16'h0FFF, 3'b010);
         boot(8'h00, 8'h00, 8'h00, 8'h06, 8'h00, 8'hC5);
         fa(16'h0700, 3'b100);
         boot(8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hC5);
         fa(16'h0F00, 3'b100);
         $display("scan and flash test done");
      end
   endtask
   task t_start;
      begin
         for (k = 0; k < 8; k = k + 1) begin
            boot(8'h00, 8'h00, {5'h00, k[2:0]}, 8'h00, 8'h00, 8'hC5);
            e = (k == 0) ? 16'h0000 : (16'h0004 << (k - 1));
            n = 0;
            while (startup_done_o !== 1'b1 && n < 400) begin
               tick;
               n = n + 1;
            end
            chk(1, n >= e && n <= e + 1);
         end
         $display("start-up test done");
      end
   endtask
   task t_guard;
      begin
         pin_gpio_oe_n_i <= 0;
         pin_gpio_out_i <= 1;
         boot(8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hC5);
         chk(2'b11, {pin_guard_active_o, pin_oe_n_o});
         repeat (6) @(posedge slow_osc_i);
         tick;
         chk(1, pin_oe_n_o);
         repeat (3) @(posedge slow_osc_i);
         repeat (5) tick;
         chk(2'b00, {pin_guard_active_o, pin_oe_n_o});
         // pin_gpio_oe_n_i was low all through the guard; now the output level changes
         pin_gpio_out_i <= 0;
         tick;
         chk(0, pin_out_o);
         rdchk(4'hC, 8'h09);
         $display("pin guard test done");
      end
   endtask
   task complete_run;
      begin
         $display("checks=%0d fail_count=%0d", checks, fail_count);
         if (fail_count == 0 && checks > 0)
            $display("Testbench passed");
         else
            $display("Testbench failed");
         $finish;
      end
   endtask
   initial begin
      t_timer;
      t_regs;
      t_scan;
      t_start;
      t_guard;
      complete_run;
   end
endmodule

// ---- tb/fcd_fuse_sva.sv ----
`timescale 1ns/1ps
module fcd_fuse_sva (
   input wire sys_clk_i,
   input wire rst_n_i,
   input wire [7:0] fuse_syscfg_a_i,
   input wire chip_erase_i,
   input wire dbg_sysbus_req_i,
   input wire dbg_sib_req_i,
   input wire [7:0] timer_fault_control_o,
   input wire [1:0] scan_source_select_o,
   input wire scan_disabled_o,
   input wire [1:0] reset_pin_function_o,
   input wire pin_is_gpio_o,
   input wire pin_oe_n_o,
   input wire pin_guard_active_o,
   input wire erase_eeprom_o,
   input wire locked_o,
   input wire dbg_sysbus_grant_o,
   input wire dbg_sib_grant_o
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!rst_n_i);
   a_cfg_held: assert property ($past(rst_n_i, 2) |-> $stable({timer_fault_control_o, scan_source_select_o,
      reset_pin_function_o})) else $error("config moved after load");
   a_erase_keep: assert property ($past(rst_n_i, 2) |-> erase_eeprom_o ==
      (chip_erase_i && (locked_o || !fuse_syscfg_a_i[0]))) else $error("eeprom erase wrong");
   a_bus_locked: assert property (dbg_sysbus_grant_o |-> dbg_sysbus_req_i && !locked_o)
      else $error("bus granted while locked");
   a_sib_open: assert property ($past(rst_n_i, 2) && dbg_sib_req_i |-> dbg_sib_grant_o)
      else $error("info block refused");
   a_guard_off: assert property (pin_guard_active_o || !pin_is_gpio_o |-> pin_oe_n_o)
      else $error("pin driven in guard");
   a_scan_none: assert property ($past(rst_n_i, 2) |-> scan_disabled_o == (scan_source_select_o == 2'h3))
      else $error("scan disable wrong");
   a_gpio_code: assert property ($past(rst_n_i, 2) |-> pin_is_gpio_o == (reset_pin_function_o == 2'h0))
      else $error("gpio decode wrong");
   a_reset_lock: assert property (disable iff (1'b0) !rst_n_i ##1 !rst_n_i |-> locked_o && pin_guard_active_o
      && !dbg_sysbus_grant_o) else $error("reset state open");
   c_bus: cover property (dbg_sysbus_grant_o);
   c_erase: cover property (erase_eeprom_o);
   c_guard: cover property ($fell(pin_guard_active_o));
endmodule
bind fcd_fuse_decoder fcd_fuse_sva u_sva (.sys_clk_i, .rst_n_i, .fuse_syscfg_a_i, .chip_erase_i,
   .dbg_sysbus_req_i, .dbg_sib_req_i, .timer_fault_control_o, .scan_source_select_o, .scan_disabled_o,
   .reset_pin_function_o, .pin_is_gpio_o, .pin_oe_n_o, .pin_guard_active_o, .erase_eeprom_o, .locked_o,
   .dbg_sysbus_grant_o, .dbg_sib_grant_o);
